// *** hw/ftsram_regs.svh ***
// Purpose: Constants for the flow-through synchronous memory access front end.
// Assumes: Core clock of 50 MHz.
// Notes:   Times are kept in picoseconds so that the cycle counts stay integral.
`ifndef FTSRAM_REGS_SVH
`define FTSRAM_REGS_SVH
`define FTSRAM_CLK_PERIOD_PS 20000
`define FTSRAM_CDV_MAX_PS 6500
`define FTSRAM_CDV_CYCLES (((`FTSRAM_CDV_MAX_PS / `FTSRAM_CLK_PERIOD_PS) < 1) ? 1 : (`FTSRAM_CDV_MAX_PS / `FTSRAM_CLK_PERIOD_PS))
`define FTSRAM_BURST_BITS 2
`define FTSRAM_BURST_LSB 0
`endif

// *** hw/ftsram_pkg.sv ***
// Purpose: Types used by the access front end, not by its memory array.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds the pipeline state enumeration only.
`default_nettype none
package ftsram_pkg;
  typedef enum logic [1:0] {
    FTSRAM_IDLE,
    FTSRAM_READ,
    FTSRAM_WRITE
  } ftsram_op_t;
endpackage : ftsram_pkg
`default_nettype wire

// *** hw/ftsram_mem_if.sv ***
// Purpose: Write and read port bundle between the front end and the array.
// Assumes: One clock.
// Notes:   Width and depth follow the parameters of the front end.
`timescale 1ns/100ps
`default_nettype none
interface ftsram_mem_if #(
  parameter int AW = 8,
  parameter int LANES = 4,
  parameter int LW = 9
);
  logic [AW-1:0]       wr_addr;
  logic [LANES*LW-1:0] wr_data;
  logic [LANES-1:0]    wr_lane;
  logic                wr_en;
  logic [AW-1:0]       rd_addr;
  logic [LANES*LW-1:0] rd_data;
  modport ctrl (output wr_addr, output wr_data, output wr_lane, output wr_en, output rd_addr, input rd_data);
  modport array (input wr_addr, input wr_data, input wr_lane, input wr_en, input rd_addr, output rd_data);
endinterface : ftsram_mem_if
`default_nettype wire

// *** hw/ftsram_array.sv ***
// Purpose: Storage array with per-lane write masking and a registered read.
// Assumes: Writes are enabled only on qualified clock edges by the front end.
// Notes:   Read data is registered so the output pins come from flip-flops.
`timescale 1ns/100ps
`default_nettype none
module ftsram_array #(
  parameter int AW = 8,
  parameter int LANES = 4,
  parameter int LW = 9
) (
  input  wire logic core_clk,
  input  wire logic rd_en,
  ftsram_mem_if.array m
);
  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];
  logic [LANES*LW-1:0] rd_r;

  always_ff @(posedge core_clk)
  begin
    if (m.wr_en)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (m.wr_lane[i])
        begin
          mem[m.wr_addr][i*LW +: LW] <= m.wr_data[i*LW +: LW];
        end
      end
    end
    if (rd_en)
    begin
      rd_r <= mem[m.rd_addr];
    end
  end

  assign m.rd_data = rd_r;
endmodule : ftsram_array
`default_nettype wire

// *** hw/ftsram_access.sv ***
// Purpose: Synchronous access front end of a flow-through burst memory.
// Assumes: All control pins come from logic on core_clk; the strap is quasi-static.
// Notes:   Data pins are split into input, output and output enable.
// Notes on behaviour
// - A low strap selects linear burst order, a high strap selects interleaved order.
// - Address, controls and write data are captured into input registers on the rising clock edge.
// - A high clock-qualify input freezes every piece of internal state for that edge.
// - A new address is latched only with all chip selects active, clock-qualify low and load/advance low.
// - A started access is a write if the write strobe is active at the load edge, else a read.
// - A write updates only byte lanes, parity included, whose active-low lane select is asserted.
// - Writes complete internally with no extra cycles from the controller.
// - Reads, writes and deselects are pipelined so one may be accepted every clock.
// - Read data is valid within the clock-to-data delay of the edge that registered the read.
// - Data and parity lines float during write data, the first cycle after deselect, and while deselected.
// - Selection needs the first and third chip selects low and the second high.
// - A high load/advance steps the burst counter unless deselected, ignores selects and strobe, and keeps the access type.
// - The burst counter acts only on the two lowest address bits and wraps within four.
`timescale 1ns/100ps
`default_nettype none
`include "ftsram_regs.svh"
module ftsram_access #(
  parameter int AW = 8,
  parameter int LANES = 4,
  parameter int LW = 9
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [AW-1:0]       addr,
  input  wire logic                clock_qualify_n,
  input  wire logic                chip_select_a_n,
  input  wire logic                chip_select_b,
  input  wire logic                chip_select_c_n,
  input  wire logic                advance_or_load,
  input  wire logic                write_n,
  input  wire logic [LANES-1:0]    byte_lane_select_n,
  input  wire logic                output_enable_n,
  input  wire logic                burst_mode,
  input  wire logic [LANES*LW-1:0] data_in,
  output logic      [LANES*LW-1:0] data_out,
  output logic      [LANES-1:0]    data_oe
);
  localparam int BB = `FTSRAM_BURST_BITS;

  logic [AW-1:0]          base_r, base_nxt;
  logic [BB-1:0]          cnt_r, cnt_nxt;
  logic                   mode_r, mode_nxt;
  ftsram_pkg::ftsram_op_t op_r, op_nxt;
  logic                   desel_r, desel_nxt;
  logic                   wr_pend_r, wr_pend_nxt;
  logic [AW-1:0]          wr_addr_r, wr_addr_nxt;
  logic [LANES-1:0]       wr_lane_r, wr_lane_nxt;
  logic [LANES-1:0]       oe_r, oe_nxt;
  logic                   qual;
  logic                   load;
  logic                   selected;
  logic                   first_load;
  logic [BB-1:0]          low_bits;
  logic [AW-1:0]          cur_addr;

  ftsram_mem_if #(.AW(AW), .LANES(LANES), .LW(LW)) mif ();

  ftsram_array #(.AW(AW), .LANES(LANES), .LW(LW)) u_array (
    .core_clk (core_clk),
    .rd_en    (qual),
    .m        (mif)
  );

  assign qual       = !clock_qualify_n;
  assign load       = !advance_or_load;
  assign selected   = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  // A load that ends a deselect keeps the lines off for one cycle, so the bus can turn round.
  assign first_load = load && selected && desel_r;

  // Burst address group: base address, burst counter and burst order strap.
  always_comb
  begin
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    mode_nxt = burst_mode;
    if (load)
    begin
      if (selected)
      begin
        base_nxt = addr;
        cnt_nxt  = '0;
      end
    end
    else if (!desel_r)
    begin
      cnt_nxt = cnt_r + BB'(1);
    end
    // The order comes from the previous edge, so a strap that moves mid burst changes the order one edge later.
    unique case (mode_r)
      1'b0:
      begin
        low_bits = base_nxt[BB-1:0] + cnt_nxt;
      end
      1'b1:
      begin
        low_bits = base_nxt[BB-1:0] ^ cnt_nxt;
      end
    endcase
    cur_addr = {base_nxt[AW-1:BB], low_bits};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_r <= '0;
      cnt_r  <= '0;
      mode_r <= 1'b1;
    end
    else if (qual)
    begin
      base_r <= base_nxt;
      cnt_r  <= cnt_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Command group: an advance keeps the access type of the running burst.
  always_comb
  begin
    op_nxt    = op_r;
    desel_nxt = desel_r;
    if (load)
    begin
      if (selected)
      begin
        op_nxt    = write_n ? ftsram_pkg::FTSRAM_READ : ftsram_pkg::FTSRAM_WRITE;
        desel_nxt = 1'b0;
      end
      else
      begin
        op_nxt    = ftsram_pkg::FTSRAM_IDLE;
        desel_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_r    <= ftsram_pkg::FTSRAM_IDLE;
      desel_r <= 1'b1;
    end
    else if (qual)
    begin
      op_r    <= op_nxt;
      desel_r <= desel_nxt;
    end
  end

  // Write slot: the data of a write arrives one edge after its command, so address and lanes wait here.
  always_comb
  begin
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_lane_nxt = wr_lane_r;
    if (op_nxt == ftsram_pkg::FTSRAM_WRITE && !desel_nxt)
    begin
      wr_pend_nxt = 1'b1;
      wr_addr_nxt = cur_addr;
      wr_lane_nxt = ~byte_lane_select_n;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      wr_lane_r <= '0;
    end
    else if (qual)
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_lane_r <= wr_lane_nxt;
    end
  end

  // Output group: the lines are driven only for a read that does not follow a deselect.
  always_comb
  begin
    oe_nxt = '0;
    unique case (op_nxt)
      ftsram_pkg::FTSRAM_READ:
      begin
        if (!desel_nxt && !first_load && !output_enable_n)
        begin
          oe_nxt = '1;
        end
      end
      ftsram_pkg::FTSRAM_WRITE:
      begin
        oe_nxt = '0;
      end
      ftsram_pkg::FTSRAM_IDLE:
      begin
        oe_nxt = '0;
      end
      default:
      begin
        oe_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_r <= '0;
    end
    else if (qual)
    begin
      oe_r <= oe_nxt;
    end
  end

  // Write data follows the command by one edge, so the array write uses the pending slot.
  assign mif.wr_en   = wr_pend_r && qual;
  assign mif.wr_addr = wr_addr_r;
  assign mif.wr_lane = wr_lane_r;
  assign mif.wr_data = data_in;
  assign mif.rd_addr = cur_addr;

  // Read data lands on the edge that registers the read command, well inside the access time at this rate.
  assign data_out = mif.rd_data;
  assign data_oe  = oe_r;
endmodule : ftsram_access
`default_nettype wire

// *** bench/ftsram_ctl_model.sv ***
// Purpose: Controller side of the shared data lines.
// Assumes: One clock; the bench decides when to drive.
// Notes:   Undriven lines show the inverse of their last level, so stale data never matches.
`timescale 1ns/100ps
`default_nettype none
module ftsram_ctl_model (
  input  wire logic        core_clk,
  input  wire logic [35:0] drv_data,
  input  wire logic        drv_en,
  input  wire logic [35:0] dev_data,
  input  wire logic [3:0]  dev_oe,
  output logic      [35:0] bus,
  output var logic         clash
);
  logic [35:0] last_r = '0;
  initial clash = 1'b0;
  always_comb bus = drv_en ? drv_data : (|dev_oe ? dev_data : ~last_r);
  always @(posedge core_clk)
  begin
    last_r <= bus;
    clash  <= clash | (drv_en & |dev_oe);
  end
endmodule : ftsram_ctl_model
`default_nettype wire

// *** bench/ftsram_access_monitor.sv ***
// Purpose: Pin checks of the access front end.
// Assumes: Bound to the top module; one clock.
// Notes:   Output enables follow the sampling edge by one cycle.
`timescale 1ns/100ps
`default_nettype none
module ftsram_access_monitor #(
  parameter int LANES = 4,
  parameter int LW    = 9
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                clock_qualify_n,
  input wire logic                chip_select_a_n,
  input wire logic                chip_select_b,
  input wire logic                chip_select_c_n,
  input wire logic                advance_or_load,
  input wire logic                write_n,
  input wire logic                output_enable_n,
  input wire logic [LANES*LW-1:0] data_out,
  input wire logic [LANES-1:0]    data_oe
);
  wire logic go  = !clock_qualify_n && !advance_or_load;
  wire logic adv = !clock_qualify_n && advance_or_load;
  wire logic sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_freeze; clock_qualify_n |=> $stable(data_out) && $stable(data_oe); endproperty
  a_freeze: assert property (p_freeze) else $error("Outputs moved while frozen");
  property p_desel; go && !sel |=> data_oe == '0; endproperty
  a_desel: assert property (p_desel) else $error("Driving after deselect");
  property p_wr; go && sel && !write_n |=> data_oe == '0; endproperty
  a_wr: assert property (p_wr) else $error("Driving in write data cycle");
  property p_oen; !clock_qualify_n && output_enable_n |=> data_oe == '0; endproperty
  a_oen: assert property (p_oen) else $error("Driving with output enable high");
  property p_rd; go && sel && write_n ##1 go && sel && write_n && !output_enable_n |=> data_oe == '1; endproperty
  a_rd: assert property (p_rd) else $error("Back to back read not driven");
  property p_wburst; go && sel && !write_n ##1 adv |=> data_oe == '0; endproperty
  a_wburst: assert property (p_wburst) else $error("Write burst turned to read");
  property p_dadv; go && !sel ##1 adv |=> data_oe == '0; endproperty
  a_dadv: assert property (p_dadv) else $error("Advance revived a deselect");
  property p_rise; $rose(data_oe[0]) |-> !$past(clock_qualify_n) && !$past(output_enable_n); endproperty
  a_rise: assert property (p_rise) else $error("Enable rose without cause");
endmodule : ftsram_access_monitor
`default_nettype wire

// *** bench/test_ftsram_access.sv ***
// Purpose: Directed access sequences for the memory front end.
// Assumes: Write data travels one edge behind its command.
// Notes:   Stored words are coined from their address, except the zero lanes that the lane test writes.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
begin \
  tests_run++; \
  if ((s) !== (e)) \
  begin \
    error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); \
  end \
end
module test_ftsram_access;
  localparam logic [1:0] LDW = 2'b00, LDR = 2'b01, ADV = 2'b11;
  localparam logic [2:0] ON = 3'b010;
  logic        core_clk = 0, rst_n = 0, cq = 0, adv = 0, wn = 1, oen = 0, mode = 1, de = 0, sa = 1, sb = 0, sc = 1;
  logic        nm = 1, noe = 0, ncq = 0, clash;
  logic [7:0]  a = '0;
  logic [3:0]  ln = 4'hf, oe;
  logic [35:0] dd = '0, din, dout;
  int          error_cnt = 0, tests_run = 0;
  logic [2:0]  dsel [3] = '{3'b110, 3'b000, 3'b011};
  always #10 core_clk = ~core_clk;
  ftsram_access ftsram_access_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(a), .clock_qualify_n(cq),
    .chip_select_a_n(sa), .chip_select_b(sb), .chip_select_c_n(sc), .advance_or_load(adv), .write_n(wn),
    .byte_lane_select_n(ln), .output_enable_n(oen), .burst_mode(mode), .data_in(din), .data_out(dout), .data_oe(oe));
  ftsram_ctl_model ftsram_ctl_model_inst (.core_clk(core_clk), .drv_data(dd), .drv_en(de), .dev_data(dout),
    .dev_oe(oe), .bus(din), .clash(clash));
  function automatic logic [35:0] word_of(input logic [7:0] x);
    return {4{1'b1, x}};
  endfunction : word_of
  task op(input logic [1:0] c, input logic [2:0] s, input logic [7:0] x, input logic [3:0] m, input logic e,
          input logic [35:0] d);
    @(posedge core_clk);
    {adv, wn, sa, sb, sc, a, ln, de, dd, mode, oen, cq} <= {c, s, x, m, e, d, nm, noe, ncq};
    #2;
  endtask : op
  task burst(input logic m, input logic [7:0] x, input logic [7:0] ord);
    nm = m;
    op(LDR, ON, x, 4'hf, 0, '0);
    for (int k = 0; k < 4; k++)
    begin
      op(ADV, 3'b000, 8'h00, 4'hf, 0, '0);
      `CHK("burst", word_of({x[7:2], ord[7-2*k -: 2]}), dout)
      if (k > 0) `CHK("burst oe", 4'hf, oe)
    end
    $display("Test burst %0d done", m);
  endtask : burst
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial
  begin
    #20000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1;
    op(LDW, ON, 8'h20, 4'h0, 0, '0);
    for (int i = 0; i < 4; i++)
      op(i < 3 ? ADV : LDR, i < 3 ? ON : 3'b110, 8'h00, 4'h0, 1, word_of(8'(8'h20 + i)));
    op(LDW, ON, 8'h10, 4'h0, 0, '0);
    op(LDR, 3'b000, 8'h10, 4'h0, 1, word_of(8'h10));
    op(LDW, ON, 8'h10, 4'h5, 0, '0);
    op(LDR, 3'b000, 8'h10, 4'h5, 1, '0);
    op(LDR, ON, 8'h10, 4'hf, 0, '0);
    `CHK("oe desel", 4'h0, oe)
    op(LDR, ON, 8'h20, 4'hf, 0, '0);
    `CHK("oe first", 4'h0, oe)
    `CHK("lanes", {9'h000, 9'h110, 9'h000, 9'h110}, dout)
    $display("Test writes done");
    burst(0, 8'h21, 8'h6c);
    burst(1, 8'h22, 8'hb1);
    noe = 1;
    repeat (3) op(LDR, ON, 8'h20, 4'hf, 0, '0);
    `CHK("oe masked", 4'h0, oe)
    noe = 0;
    foreach (dsel[i])
    begin
      op(LDR, ON, 8'h20, 4'hf, 0, '0);
      op(LDR, ON, 8'h21, 4'hf, 0, '0);
      op(LDR, dsel[i], 8'h22, 4'hf, 0, '0);
      `CHK("oe read", 4'hf, oe)
      op(ADV, ON, 8'h22, 4'hf, 0, '0);
      `CHK("oe off", 4'h0, oe)
    end
    op(LDR, ON, 8'h21, 4'hf, 0, '0);
    ncq = 1;
    repeat (3) op(LDR, ON, 8'h23, 4'hf, 0, '0);
    `CHK("frozen", word_of(8'h21), dout)
    ncq = 0;
    repeat (2) op(LDR, ON, 8'h23, 4'hf, 0, '0);
    `CHK("thawed", word_of(8'h23), dout)
    `CHK("clash", 1'b0, clash)
    $display("Test selects done");
    stop_test;
  end
endmodule : test_ftsram_access
bind ftsram_access ftsram_access_monitor #(.LANES(LANES), .LW(LW)) ftsram_access_monitor_inst (
  .core_clk(core_clk), .rst_n(rst_n), .clock_qualify_n(clock_qualify_n), .chip_select_a_n(chip_select_a_n),
  .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n), .advance_or_load(advance_or_load),
  .write_n(write_n), .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire
